// ---- err_source_model.sv ----
// Far-side model: host-fabric flood source and per-port error detectors
// Assumes bench requests change just after a sys_clk rising edge
`default_nettype none

module err_source_model (
  input wire logic sys_clk,
  input wire logic req_flood,
  input wire logic [10:0] req_fatal,
  input wire logic [10:0] req_nonfatal,
  output var logic sync_flood = 1'b0,
  output var logic [10:0] fatal_err = 11'h000,
  output var logic [10:0] nonfatal_err = 11'h000
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Detector outputs
  // ****************************************
  // Registered like a real detector; it keeps reporting on a downed link
  always @(posedge sys_clk) begin
    sync_flood <= req_flood;
    fatal_err <= req_fatal;
    nonfatal_err <= req_nonfatal;
  end
endmodule // err_source_model

`default_nettype wire

// ---- link_disable_map.svh ----
// Register indices, field positions and reset values for link containment
// Included by bare name; holds definitions only
`ifndef LINK_DISABLE_MAP_SVH
`define LINK_DISABLE_MAP_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define IDX_CTL_LOW 8'h0d
`define IDX_CTL_HIGH 8'h4f
`define IDX_PORT_BASE 8'ha1
`define IDX_DIS_STATUS 8'h50
`define IDX_REENABLE 8'h51

// ****************************************
// Field layout
// ****************************************
`define NUM_PORTS 11
`define HW_EN_BIT 19
`define LOW_PORT_BASE 8
`define LOW_PORT_LAST 5
`define HIGH_PORT_BASE 0
`define HIGH_PORT_FIRST 6
`define HIGH_PORT_LAST 9
`define THREE_B_BASE 4
`define FIELD_STRIDE 4
`define FLD_FATAL 0
`define FLD_NONFATAL 1
`define FLD_FLOOD 3

// ****************************************
// Reset values and responses
// ****************************************
`define CTL_RESET 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- link_disable_pkg.sv ----
// Types and shared helpers for the link containment block
// Assumes nothing of its surroundings
`default_nettype none

package link_disable_pkg;

  typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_DATA} rd_state_e;
  typedef logic [31:0] word_t;
  typedef logic [7:0] reg_idx_t;

  // Byte-lane merge of a bus write into an old word
  function automatic word_t merge_strb(word_t old_val, word_t new_val, logic [3:0] strb);
    word_t res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction

endpackage

`default_nettype wire

// ---- link_error_containment.sv ----
// Error containment: brings expansion links down on flood or port errors
// Assumes AXI4-Lite master on sys_clk; error and flood inputs synchronous
//
// Register access over AXI4-Lite is this design's own decision.
`default_nettype none
`include "link_disable_map.svh"

module link_error_containment #(
  parameter int NUM_PORTS = `NUM_PORTS,
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic sync_flood,
  input wire logic [NUM_PORTS-1:0] fatal_err,
  input wire logic [NUM_PORTS-1:0] nonfatal_err,
  output logic [NUM_PORTS-1:0] link_disable,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ****************************************
  // Reset release
  // ****************************************
  // Runs regardless of ce so the block never sits in reset forever
  logic rst_meta;
  logic rst_sync_b;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic link_disable_pkg::reg_idx_t addr_to_idx(logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  function automatic logic is_port_idx(link_disable_pkg::reg_idx_t idx);
    return idx >= `IDX_PORT_BASE && idx < `IDX_PORT_BASE + 8'(NUM_PORTS);
  endfunction

  function automatic logic is_mapped(link_disable_pkg::reg_idx_t idx);
    return idx == `IDX_CTL_LOW || idx == `IDX_CTL_HIGH || is_port_idx(idx)
      || idx == `IDX_DIS_STATUS || idx == `IDX_REENABLE;
  endfunction

  // Response bit of one port: fld selects fatal, non-fatal or flood
  function automatic logic field_bit(link_disable_pkg::word_t low,
    link_disable_pkg::word_t high, int port, int fld);
    logic res;
    res = 1'b0;
    if (port <= `LOW_PORT_LAST) begin
      res = low[`LOW_PORT_BASE + `FIELD_STRIDE * port + fld];
    end else if (port <= `HIGH_PORT_LAST) begin
      res = high[`HIGH_PORT_BASE + `FIELD_STRIDE * (port - `HIGH_PORT_FIRST) + fld];
    end else begin
      res = low[`THREE_B_BASE + fld];
    end
    return res;
  endfunction

  // ****************************************
  // Write channel
  // ****************************************
  port_reg_if #(.NUM_PORTS(NUM_PORTS)) regs ();

  logic aw_held;
  logic w_held;
  link_disable_pkg::reg_idx_t aw_idx;
  link_disable_pkg::word_t w_data;
  logic [3:0] w_strb;
  link_disable_pkg::word_t ctl_low;
  link_disable_pkg::word_t ctl_high;

  wire aw_hs = awvalid && awready && ce;
  wire w_hs = wvalid && wready && ce;
  wire do_write = aw_held && w_held && !bvalid;
  wire wr_go = do_write && ce;
  wire wr_low = wr_go && aw_idx == `IDX_CTL_LOW;
  wire wr_high = wr_go && aw_idx == `IDX_CTL_HIGH;
  wire wr_reenable = wr_go && aw_idx == `IDX_REENABLE;
  wire link_disable_pkg::word_t clr_word = link_disable_pkg::merge_strb(`CTL_RESET,
    w_data, w_strb);
  wire [NUM_PORTS-1:0] clr_vec = wr_reenable ? clr_word[NUM_PORTS-1:0] : '0;

  // Address and data may arrive in either order; each waits for the other
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      aw_held <= 1'b0;
      aw_idx <= 8'h00;
    end else if (ce) begin
      if (do_write) begin
        aw_held <= 1'b0;
      end else if (aw_hs) begin
        aw_held <= 1'b1;
        aw_idx <= addr_to_idx(awaddr);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      w_held <= 1'b0;
      w_data <= `CTL_RESET;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (do_write) begin
        w_held <= 1'b0;
      end else if (w_hs) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= is_mapped(aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctl_low <= `CTL_RESET;
      ctl_high <= `CTL_RESET;
    end else begin
      if (wr_low) begin
        ctl_low <= link_disable_pkg::merge_strb(ctl_low, w_data, w_strb);
      end
      if (wr_high) begin
        ctl_high <= link_disable_pkg::merge_strb(ctl_high, w_data, w_strb);
      end
    end
  end

  assign regs.we = wr_go && is_port_idx(aw_idx);
  assign regs.wr_port = 4'(aw_idx - `IDX_PORT_BASE);
  assign regs.wdata = w_data;
  assign regs.wstrb = w_strb;

  port_reg_bank #(.NUM_PORTS(NUM_PORTS)) bank (
    .sys_clk(sys_clk),
    .rst_sync_b(rst_sync_b),
    .regs(regs)
  );

  // ****************************************
  // Read channel
  // ****************************************
  link_disable_pkg::rd_state_e rd_state;
  link_disable_pkg::rd_state_e next_rd_state;
  link_disable_pkg::reg_idx_t rd_idx;
  link_disable_pkg::word_t next_rdata;

  wire ar_hs = arvalid && arready && ce;
  wire link_disable_pkg::reg_idx_t ar_idx = addr_to_idx(araddr);

  assign arready = rd_state == link_disable_pkg::RD_IDLE;
  assign rvalid = rd_state == link_disable_pkg::RD_DATA;
  assign regs.re = ar_hs && is_port_idx(ar_idx);
  assign regs.rd_port = 4'(ar_idx - `IDX_PORT_BASE);

  // Port words come out of the bank one cycle late, hence the fetch step
  assign next_rdata = rd_idx == `IDX_CTL_LOW ? ctl_low :
    rd_idx == `IDX_CTL_HIGH ? ctl_high :
    is_port_idx(rd_idx) ? regs.rdata :
    rd_idx == `IDX_DIS_STATUS ? 32'(link_disable) : `CTL_RESET;

  always_comb begin
    next_rd_state = rd_state;
    case (rd_state)
      link_disable_pkg::RD_IDLE: begin
        if (arvalid) begin
          next_rd_state = link_disable_pkg::RD_FETCH;
        end
      end
      link_disable_pkg::RD_FETCH: begin
        next_rd_state = link_disable_pkg::RD_DATA;
      end
      link_disable_pkg::RD_DATA: begin
        if (rready) begin
          next_rd_state = link_disable_pkg::RD_IDLE;
        end
      end
      default: begin
        next_rd_state = link_disable_pkg::RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rd_state <= link_disable_pkg::RD_IDLE;
      rd_idx <= 8'h00;
      rdata <= `CTL_RESET;
      rresp <= `RESP_OKAY;
    end else if (ce) begin
      rd_state <= next_rd_state;
      if (ar_hs) begin
        rd_idx <= ar_idx;
      end
      if (rd_state == link_disable_pkg::RD_FETCH) begin
        rdata <= next_rdata;
        rresp <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // Containment
  // ****************************************
  logic [NUM_PORTS-1:0] flood_en;
  logic [NUM_PORTS-1:0] fatal_en;
  logic [NUM_PORTS-1:0] nonfatal_en;

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_field
    assign flood_en[i] = field_bit(ctl_low, ctl_high, i, `FLD_FLOOD);
    assign fatal_en[i] = field_bit(ctl_low, ctl_high, i, `FLD_FATAL);
    assign nonfatal_en[i] = field_bit(ctl_low, ctl_high, i, `FLD_NONFATAL);
  end

  // Port enable gates every cause, flood included
  wire [NUM_PORTS-1:0] flood_armed = regs.hw_en & flood_en;
  wire [NUM_PORTS-1:0] fatal_hit = regs.hw_en & fatal_en & fatal_err;
  wire [NUM_PORTS-1:0] nonfatal_hit = regs.hw_en & nonfatal_en & nonfatal_err;
  wire [NUM_PORTS-1:0] cause = (sync_flood ? flood_armed : '0) | fatal_hit | nonfatal_hit;
  // A fresh cause beats a re-enable in the same cycle
  wire [NUM_PORTS-1:0] next_link_disable = cause | (link_disable & ~clr_vec);

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      link_disable <= '0;
    end else if (ce) begin
      link_disable <= next_link_disable;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_b);

  sequence s_ar_taken;
    arvalid && arready && ce;
  endsequence

  sequence s_write_ready;
    ce && aw_held && w_held && !bvalid;
  endsequence

  chk_flood_disable: assert property (
    ce && sync_flood |=> &(link_disable | ~$past(flood_armed)))
    else $error("flood did not drop armed links");

  chk_fatal_disable: assert property (
    ce |=> &(link_disable | ~$past(fatal_hit)))
    else $error("fatal error did not drop link");

  chk_nonfatal_disable: assert property (
    ce |=> &(link_disable | ~$past(nonfatal_hit)))
    else $error("non-fatal error did not drop link");

  chk_enable_gate: assert property (
    1'b1 |=> ((link_disable & ~$past(link_disable)) & ~$past(regs.hw_en)) == '0)
    else $error("link dropped without port enable");

  chk_disable_sticky: assert property (
    1'b1 |=> (($past(link_disable) & ~link_disable) & ~$past(clr_vec)) == '0)
    else $error("link re-enabled without software");

  chk_ctl_low_write: assert property (
    wr_low && w_strb == 4'hf |=> ctl_low == $past(w_data))
    else $error("low control word not written");

  chk_write_answer: assert property (
    s_write_ready |=> bvalid ##0 (bresp == `RESP_OKAY) == $past(is_mapped(aw_idx)))
    else $error("write response missing or wrong");

  chk_resp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

  chk_read_answer: assert property (
    s_ar_taken ##1 ce |=> rvalid)
    else $error("read data late");

  chk_read_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");

endmodule // link_error_containment

`default_nettype wire

// ---- port_reg_bank.sv ----
// Per-port error link control words, one per expansion port
// Assumes ports below NUM_PORTS only; write and read strobes already gated
`default_nettype none
`include "link_disable_map.svh"

module port_reg_bank #(
  parameter int NUM_PORTS = `NUM_PORTS
) (
  input wire logic sys_clk,
  input wire logic rst_sync_b,
  port_reg_if.bank regs
);

  link_disable_pkg::word_t mem [NUM_PORTS];

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        mem[i] <= `CTL_RESET;
      end
    end else if (regs.we) begin
      mem[regs.wr_port] <= link_disable_pkg::merge_strb(mem[regs.wr_port],
        regs.wdata, regs.wstrb);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      regs.rdata <= `CTL_RESET;
    end else if (regs.re) begin
      regs.rdata <= mem[regs.rd_port];
    end
  end

  // One hardware-disable enable per port, seen all at once
  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_en
    assign regs.hw_en[i] = mem[i][`HW_EN_BIT];
  end

  chk_hw_en_write: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
    regs.we && regs.wstrb[2] |=> regs.hw_en[$past(regs.wr_port)] == $past(regs.wdata[19]))
    else $error("port enable bit not stored");

endmodule // port_reg_bank

`default_nettype wire

// ---- port_reg_if.sv ----
// Carrier between the bus slave and the per-port register bank
// Assumes both ends run on the same clock
`default_nettype none

interface port_reg_if #(parameter int NUM_PORTS = 11);
  logic we;
  logic [3:0] wr_port;
  link_disable_pkg::word_t wdata;
  logic [3:0] wstrb;
  logic re;
  logic [3:0] rd_port;
  link_disable_pkg::word_t rdata;
  logic [NUM_PORTS-1:0] hw_en;

  modport ctrl (output we, wr_port, wdata, wstrb, re, rd_port, input rdata, hw_en);
  modport bank (input we, wr_port, wdata, wstrb, re, rd_port, output rdata, hw_en);
endinterface

`default_nettype wire

// ---- tb_link_error_containment.sv ----
// Self-checking bench for the link containment block
// Assumes the block's register map header and an AXI4-Lite slave
`default_nettype none
`include "link_disable_map.svh"

module tb_link_error_containment;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk;
  logic rst_b;
  logic ce;
  logic req_flood;
  logic sync_flood;
  logic [10:0] req_fatal;
  logic [10:0] req_nonfatal;
  logic [10:0] fatal_err;
  logic [10:0] nonfatal_err;
  logic [10:0] link_disable;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic awvalid;
  logic awready;
  logic wvalid;
  logic wready;
  logic bvalid;
  logic bready;
  logic arvalid;
  logic arready;
  logic rvalid;
  logic rready;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] lo;
  logic [31:0] hi;
  logic [3:0] wstrb;
  logic [3:0] strb = 4'hf;
  logic [1:0] bresp;
  logic [1:0] rresp;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int fld;

  link_error_containment #(.NUM_PORTS(11), .ADDR_W(12)) link_error_containment_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .sync_flood(sync_flood),
    .fatal_err(fatal_err), .nonfatal_err(nonfatal_err), .link_disable(link_disable),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  err_source_model err_source_model_i (
    .sys_clk(sys_clk), .req_flood(req_flood), .req_fatal(req_fatal),
    .req_nonfatal(req_nonfatal), .sync_flood(sync_flood), .fatal_err(fatal_err),
    .nonfatal_err(nonfatal_err)
  );

  // ****************************************
  // Clock, timeout and verdict
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run needs under a thousand cycles; a hung handshake ends here
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // ****************************************
  // Bus and stimulus tasks
  // ****************************************
  task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    bit aw_done = 0;
    bit w_done = 0;
    @(posedge sys_clk);
    awaddr <= {2'b00, idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= strb;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge sys_clk);
      if (awvalid && awready) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge sys_clk);
    bready <= 1'b0;
    compare("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic reg_read(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    compare("rdata", exp, rdata);
    compare("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  // One-cycle causes from the far side, then idle so a held link shows
  task automatic inject(input logic fl, input logic [10:0] fa, input logic [10:0] nf);
    @(posedge sys_clk);
    req_flood <= fl;
    req_fatal <= fa;
    req_nonfatal <= nf;
    @(posedge sys_clk);
    req_flood <= 1'b0;
    req_fatal <= 11'h000;
    req_nonfatal <= 11'h000;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic links(input logic [10:0] exp);
    compare("link_disable", {21'h0, exp}, {21'h0, link_disable});
  endtask

  // Response bit of each port, in link_disable order; 6..9 live in the high word
  int flood_pos [11] = '{11, 15, 19, 23, 27, 31, 3, 7, 11, 15, 7};
  int fatal_pos [11] = '{8, 12, 16, 20, 24, 28, 0, 4, 8, 12, 4};
  int nonfatal_pos [11] = '{9, 13, 17, 21, 25, 29, 1, 5, 9, 13, 5};

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    req_flood = 1'b0;
    req_fatal = 11'h000;
    req_nonfatal = 11'h000;
    awaddr = 12'h000;
    araddr = 12'h000;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reg_read(`IDX_CTL_LOW, 32'h0000_0000, `RESP_OKAY);
    reg_read(`IDX_CTL_HIGH, 32'h0000_0000, `RESP_OKAY);
    reg_read(`IDX_PORT_BASE + 8'h0a, 32'h0000_0000, `RESP_OKAY);
    reg_read(8'h00, 32'h0000_0000, `RESP_SLVERR);
    reg_write(`IDX_CTL_LOW, 32'hffff_ffff, `RESP_OKAY);
    reg_write(`IDX_CTL_HIGH, 32'h0000_ffff, `RESP_OKAY);
    strb = 4'h2;
    reg_write(`IDX_CTL_LOW, 32'h0000_0000, `RESP_OKAY);
    reg_read(`IDX_CTL_LOW, 32'hffff_00ff, `RESP_OKAY);
    strb = 4'hf;
    reg_write(`IDX_CTL_LOW, 32'hffff_ffff, `RESP_OKAY);
    reg_write(8'h00, 32'hffff_ffff, `RESP_SLVERR);
    reg_read(`IDX_CTL_LOW, 32'hffff_ffff, `RESP_OKAY);
    inject(1'b1, 11'h7ff, 11'h7ff);
    links(11'h000);
    for (int p = 0; p < 11; p++) begin
      if (p != 3) reg_write(`IDX_PORT_BASE + 8'(p), 32'h0008_0000, `RESP_OKAY);
    end
    reg_read(`IDX_PORT_BASE + 8'h03, 32'h0000_0000, `RESP_OKAY);
    reg_read(`IDX_PORT_BASE + 8'h02, 32'h0008_0000, `RESP_OKAY);
    inject(1'b1, 11'h000, 11'h000);
    links(11'h7f7);
    reg_read(`IDX_DIS_STATUS, 32'h0000_07f7, `RESP_OKAY);
    reg_write(`IDX_DIS_STATUS, 32'h0000_0000, `RESP_OKAY);
    links(11'h7f7);
    reg_write(`IDX_REENABLE, 32'h0000_0001, `RESP_OKAY);
    links(11'h7f6);
    reg_write(`IDX_REENABLE, 32'h0000_07ff, `RESP_OKAY);
    links(11'h000);
    reg_write(`IDX_PORT_BASE + 8'h03, 32'h0008_0000, `RESP_OKAY);
    ce <= 1'b0;
    inject(1'b1, 11'h7ff, 11'h7ff);
    ce <= 1'b1;
    links(11'h000);
    // Each port and kind alone, cause raised on every port at once
    for (int p = 0; p < 11; p++) begin
      for (int k = 0; k < 3; k++) begin
        fld = (k == 0) ? fatal_pos[p] : (k == 1) ? nonfatal_pos[p] : flood_pos[p];
        lo = 32'h0000_0000;
        hi = 32'h0000_0000;
        if (p >= 6 && p < 10) hi[fld] = 1'b1;
        else lo[fld] = 1'b1;
        reg_write(`IDX_CTL_LOW, lo, `RESP_OKAY);
        reg_write(`IDX_CTL_HIGH, hi, `RESP_OKAY);
        inject(k == 2, (k == 0) ? 11'h7ff : 11'h000, (k == 1) ? 11'h7ff : 11'h000);
        links(11'h001 << p);
        reg_write(`IDX_REENABLE, 32'h0000_07ff, `RESP_OKAY);
        links(11'h000);
      end
    end
    // A downed link must also come back up through a mid-run reset
    inject(1'b1, 11'h000, 11'h000);
    links(11'h400);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    links(11'h000);
    reg_read(`IDX_CTL_LOW, 32'h0000_0000, `RESP_OKAY);
    reg_read(`IDX_PORT_BASE + 8'h0a, 32'h0000_0000, `RESP_OKAY);
    complete_run();
  end
endmodule // tb_link_error_containment

`default_nettype wire
